// ---- design/uart_fifo_channel.v ----
// Serial channel with 16-byte FIFOs behind an APB register slave
// How it works
// RULE_01: Line format bit 7 redirects offsets 0 and 1 to divisor bytes.
// RULE_02: Data bits go out and come in least significant bit first.
// RULE_03: Legacy mode: transmitter-empty flag follows only the shift register.
// RULE_04: Line format: stop 2, parity 3, even 4, stick 5, break 6, access 7.
// RULE_05: Without FIFOs, FIFO-enabled bits, top ID bit, FIFO-error bit read zero.
// RULE_06: The DMA select bit of FIFO control does nothing.
// RULE_07: General outputs are plain storage; modem control bit 4 selects loopback.
// RULE_08: Legacy mode hides the scratch register from the host.
// RULE_09: Each FIFO control write is copied into a readable shadow register.
// RULE_10: Receive FIFO holds 16 bytes at every trigger level.
// RULE_11: Transmission starts as soon as a byte sits in the transmit FIFO.
// RULE_12: Writes to a full 16-character transmit FIFO are refused.
// RULE_13: Empty transmit FIFO with enable raises transmit interrupt.
// RULE_14: Empty interrupt waits one character unless two bytes coexisted.
// RULE_15: Receive count at trigger level with enable raises an interrupt.
// RULE_16: Full receive FIFO drops further characters and flags overrun.
// RULE_17: Data left untouched four character times raises timeout interrupt.
// RULE_18: Host read or new character clears timeout and restarts its timer.
// RULE_19: Character times are counted in baud reference ticks.
// RULE_20: Holding-empty interrupt clears on data write or ID register read.
// RULE_21: Line status resets to zero with both transmit-empty bits set.
// RULE_22: Trigger codes 00,01,10,11 select 1, 4, 8 and 14 bytes.
// RULE_23: Error flags travel with each character and show at the head.
//
// The implementer's own choice: register access over APB.
`default_nettype none
`include "uart_fifo_channel_regs.vh"
module uart_fifo_channel #(
  parameter FIFO_DEPTH = 16,
  parameter PTR_W      = 4
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rxd,
  input  wire        cts_n,
  input  wire        dsr_n,
  input  wire        ri_n,
  input  wire        dcd_n,
  output reg         txd,
  output reg         rts_n,
  output reg         dtr_n,
  output reg         irq
);
  localparam TX_IDLE  = 3'd0;
  localparam TX_START = 3'd1;
  localparam TX_DATA  = 3'd2;
  localparam TX_PAR   = 3'd3;
  localparam TX_STOP  = 3'd4;

  function [7:0] char_ticks;
    input [7:0] fmt;
    reg   [3:0] b;
    begin
      b = 4'd7 + {2'b00, fmt[1:0]} + {3'b000, fmt[`LF_PAR_EN]} +
          {3'b000, fmt[`LF_STOP]};
      char_ticks = {b, 4'h0}; // RULE_19
    end
  endfunction

  reg  [7:0]  line_format_q, irq_en_q, modem_ctl_q, scratch_q;
  reg  [7:0]  div_low_q, div_high_q, fifo_shadow_q;
  reg         fifo_en_q, legacy_q;
  reg  [1:0]  trig_q;
  reg  [4:0]  sync1_q, sync2_q;
  reg  [15:0] baud_cnt_q;
  reg  [2:0]  tx_st_q;
  reg  [3:0]  tx_sub_q;
  reg  [2:0]  tx_bit_q;
  reg  [7:0]  tx_sh_q;
  reg         tx_par_q, line_q;
  reg         multi_q, empty_ok_q, hold_pend_q, ie_hold_q;
  reg  [7:0]  hold_cnt_q;
  reg  [9:0]  to_cnt_q;
  reg         timeout_q, overrun_q;
  reg  [4:0]  err_cnt_q;
  reg  [3:0]  msr_prev_q, dmsr_q;
  reg         pop_ok_q, id_hold_q, oe_seen_q;
  reg  [3:0]  dmsr_seen_q;
  reg  [7:0]  rd_byte;
  reg  [3:0]  id_code;
  reg  [4:0]  trig_lvl;

  wire        div_access = line_format_q[`LF_DIV_ACCESS];
  wire        loop = modem_ctl_q[`MC_LOOP]; // RULE_07
  wire [3:0]  idx = paddr[5:2];
  wire        mapped = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) &&
                       (idx <= `IDX_FIFO_SHADOW);
  wire        setup = psel && !penable;
  wire        done_xfer = psel && penable && pready;
  wire        wr = done_xfer && pwrite && pstrb[0] && !pslverr;
  wire        rd = done_xfer && !pwrite && !pslverr;
  wire [7:0]  wb = pwdata[7:0];
  wire [15:0] divisor = {div_high_q, div_low_q};
  wire        tick = (divisor != 16'h0000) &&
                     (baud_cnt_q == divisor - 16'h0001);
  wire        rx_pin = loop ? line_q : sync2_q[0];
  wire [3:0]  msr_now = loop ? {modem_ctl_q[`MC_OUT_B],
                                modem_ctl_q[`MC_OUT_A],
                                modem_ctl_q[0], modem_ctl_q[1]} :
                               ~sync2_q[4:1];
  wire        wr_data = wr && idx == `IDX_DATA && !div_access;
  wire        wr_fcr = wr && idx == `IDX_IRQ_ID;
  wire        fen_chg = wr_fcr && (wb[`FC_ENABLE] != fifo_en_q);
  wire        rx_clr = fen_chg || (wr_fcr && wb[`FC_RX_CLR]);
  wire        tx_clr = fen_chg || (wr_fcr && wb[`FC_TX_CLR]);
  wire [4:0]  rx_cnt, tx_cnt;
  wire [10:0] rx_head;
  wire [7:0]  tx_head;
  wire [4:0]  full_lvl = fifo_en_q ? FIFO_DEPTH[4:0] : 5'h01;
  wire        tx_full = tx_cnt >= full_lvl;
  wire        rx_full = rx_cnt >= full_lvl;
  wire        tx_push = wr_data && !tx_full; // RULE_12
  wire        tx_load = (tx_st_q == TX_IDLE) && (tx_cnt != 5'h00);
  wire        rx_done;
  wire [7:0]  rx_data;
  wire        rx_pe, rx_fe, rx_bi;
  wire        rx_push = rx_done && !rx_full; // RULE_10
  wire        rx_pop = rd && idx == `IDX_DATA && !div_access && pop_ok_q;
  wire        rx_any = rx_cnt != 5'h00;
  wire [2:0]  head_err = rx_any ? rx_head[10:8] : 3'b000; // RULE_23
  wire        tx_empty = tx_cnt == 5'h00;
  wire        empty_ok = tx_empty && (hold_cnt_q == 8'h00);
  wire        sh_empty = tx_st_q == TX_IDLE && !tx_load;
  wire        tx_all = legacy_q ? sh_empty : (sh_empty && tx_empty); // RULE_03
  wire        bit_end = tick && tx_sub_q == `SUB_LAST;
  wire [7:0]  ct = char_ticks(line_format_q);
  wire [9:0]  to_limit = {ct, 2'b00} - 10'h001; // RULE_17
  wire        ls_int = irq_en_q[`IE_LINE_STAT] && (overrun_q || |head_err);
  wire        rda_int = irq_en_q[`IE_RX_DATA] &&
                        (fifo_en_q ? rx_cnt >= trig_lvl : rx_any); // RULE_15
  wire        to_int = irq_en_q[`IE_RX_DATA] && fifo_en_q && timeout_q;
  wire        he_int = irq_en_q[`IE_HOLD_EMPTY] && hold_pend_q; // RULE_13
  wire        ms_int = irq_en_q[`IE_MODEM_STAT] && (dmsr_q != 4'h0);
  wire [7:0]  line_stat = {fifo_en_q && err_cnt_q != 5'h00, tx_all, empty_ok,
                           head_err, overrun_q, rx_any}; // RULE_05 RULE_21
  wire [7:0]  id_byte = {fifo_en_q, fifo_en_q, 2'b00, id_code}; // RULE_05
  wire [7:0]  tx_mask = 8'hFF >> (2'd3 - line_format_q[1:0]);
  wire [7:0]  tx_dat = tx_head & tx_mask;

  always @* begin
    case (trig_q)
      2'd0: trig_lvl = `TRIG_LVL0; // RULE_22
      2'd1: trig_lvl = `TRIG_LVL1;
      2'd2: trig_lvl = `TRIG_LVL2;
      default: trig_lvl = `TRIG_LVL3;
    endcase
  end

  always @* begin
    if (ls_int) id_code = `ID_LINE_STAT;
    else if (rda_int) id_code = `ID_RX_DATA;
    else if (to_int) id_code = `ID_TIMEOUT;
    else if (he_int) id_code = `ID_HOLD_EMPTY;
    else if (ms_int) id_code = `ID_MODEM_STAT;
    else id_code = `ID_NONE;
  end

  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `IDX_DATA: rd_byte = div_access ? div_low_q : rx_head[7:0]; // RULE_01
      `IDX_IRQ_EN: rd_byte = div_access ? div_high_q : {4'h0, irq_en_q[3:0]};
      `IDX_IRQ_ID: rd_byte = id_byte;
      `IDX_LINE_FMT: rd_byte = line_format_q;
      `IDX_MODEM_CTL: rd_byte = {3'b000, modem_ctl_q[4:0]};
      `IDX_LINE_STAT: rd_byte = line_stat;
      `IDX_MODEM_STAT: rd_byte = {msr_now, dmsr_q};
      `IDX_SCRATCH: rd_byte = legacy_q ? 8'h00 : scratch_q; // RULE_08
      `IDX_CONFIG: rd_byte = {7'h00, legacy_q};
      `IDX_FIFO_SHADOW: rd_byte = fifo_shadow_q; // RULE_09
      default: rd_byte = 8'h00;
    endcase
  end

  // APB slave: data sampled in setup, one access cycle, side effects at end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pop_ok_q <= 1'b0;
      id_hold_q <= 1'b0;
      oe_seen_q <= 1'b0;
      dmsr_seen_q <= 4'h0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= !mapped;
        prdata <= {24'h00_0000, (mapped && !pwrite) ? rd_byte : 8'h00};
        pop_ok_q <= rx_any;
        id_hold_q <= id_code == `ID_HOLD_EMPTY;
        oe_seen_q <= overrun_q;
        dmsr_seen_q <= dmsr_q;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_format_q <= `RESET_BYTE;
      irq_en_q <= `RESET_BYTE;
      modem_ctl_q <= `RESET_BYTE;
      scratch_q <= `RESET_BYTE;
      div_low_q <= `RESET_BYTE;
      div_high_q <= `RESET_BYTE;
      fifo_shadow_q <= `RESET_BYTE;
      fifo_en_q <= 1'b0;
      trig_q <= 2'b00;
      legacy_q <= 1'b0;
    end else if (wr) begin
      case (idx)
        `IDX_DATA: if (div_access) div_low_q <= wb; // RULE_01
        `IDX_IRQ_EN: begin
          if (div_access) div_high_q <= wb;
          else irq_en_q <= {4'h0, wb[3:0]};
        end
        `IDX_IRQ_ID: begin
          fifo_shadow_q <= wb; // RULE_09
          fifo_en_q <= wb[`FC_ENABLE];
          trig_q <= wb[7:6]; // RULE_06
        end
        `IDX_LINE_FMT: line_format_q <= wb; // RULE_04
        `IDX_MODEM_CTL: modem_ctl_q <= {3'b000, wb[4:0]}; // RULE_07
        `IDX_SCRATCH: if (!legacy_q) scratch_q <= wb; // RULE_08
        `IDX_CONFIG: legacy_q <= wb[`CFG_LEGACY];
        default: legacy_q <= legacy_q;
      endcase
    end
  end

  // Pins, baud divider and modem status deltas
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 5'h1F;
      sync2_q <= 5'h1F;
      baud_cnt_q <= 16'h0000;
      msr_prev_q <= 4'h0;
      dmsr_q <= 4'h0;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      txd <= 1'b1;
      irq <= 1'b0;
    end else begin
      sync1_q <= {dcd_n, ri_n, dsr_n, cts_n, rxd};
      sync2_q <= sync1_q;
      if (tick || baud_cnt_q >= divisor - 16'h0001) baud_cnt_q <= 16'h0000;
      else baud_cnt_q <= baud_cnt_q + 16'h0001;
      msr_prev_q <= msr_now;
      dmsr_q <= (rd && idx == `IDX_MODEM_STAT ? dmsr_q & ~dmsr_seen_q : dmsr_q)
                | {msr_now[3] ^ msr_prev_q[3], !msr_now[2] && msr_prev_q[2],
                   msr_now[1] ^ msr_prev_q[1], msr_now[0] ^ msr_prev_q[0]};
      rts_n <= loop | ~modem_ctl_q[1];
      dtr_n <= loop | ~modem_ctl_q[0];
      txd <= loop | line_q;
      irq <= ls_int | rda_int | to_int | he_int | ms_int;
    end
  end

  // Transmit shifter, LSB first, starts whenever the FIFO has data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 3'd0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
      line_q <= 1'b1;
    end else begin
      if (tick) tx_sub_q <= tx_sub_q + 1'b1;
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_load) begin // RULE_11
            tx_st_q <= TX_START;
            tx_sub_q <= 4'h0;
            tx_sh_q <= tx_dat;
            tx_par_q <= line_format_q[`LF_STICK] ? ~line_format_q[`LF_EVEN] :
                        (line_format_q[`LF_EVEN] ? ^tx_dat : ~^tx_dat);
          end
        end
        TX_START: if (bit_end) begin
          tx_st_q <= TX_DATA;
          tx_bit_q <= 3'd0;
        end
        TX_DATA: if (bit_end) begin
          tx_sh_q <= {1'b0, tx_sh_q[7:1]}; // RULE_02
          tx_bit_q <= tx_bit_q + 1'b1;
          if (tx_bit_q == {1'b1, line_format_q[1:0]}) begin
            tx_st_q <= line_format_q[`LF_PAR_EN] ? TX_PAR : TX_STOP;
            tx_bit_q <= 3'd0;
          end
        end
        TX_PAR: if (bit_end) tx_st_q <= TX_STOP;
        TX_STOP: if (bit_end) begin
          tx_bit_q <= tx_bit_q + 1'b1;
          if (tx_bit_q[0] == line_format_q[`LF_STOP]) tx_st_q <= TX_IDLE;
        end
        default: tx_st_q <= TX_IDLE;
      endcase
      case (tx_st_q)
        TX_START: line_q <= line_format_q[`LF_BREAK] ? 1'b0 : 1'b0;
        TX_DATA: line_q <= tx_sh_q[0] & ~line_format_q[`LF_BREAK];
        TX_PAR: line_q <= tx_par_q & ~line_format_q[`LF_BREAK];
        default: line_q <= ~line_format_q[`LF_BREAK];
      endcase
    end
  end

  // Holding-empty interrupt with one-character holdoff
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multi_q <= 1'b0;
      hold_cnt_q <= 8'h00;
      empty_ok_q <= 1'b1;
      ie_hold_q <= 1'b0;
      hold_pend_q <= 1'b0;
    end else begin
      empty_ok_q <= empty_ok;
      ie_hold_q <= irq_en_q[`IE_HOLD_EMPTY];
      if (tx_push && tx_empty) multi_q <= 1'b0; // RULE_14
      else if (tx_cnt >= 5'h02) multi_q <= 1'b1;
      if (tx_clr) hold_cnt_q <= 8'h00;
      else if (tx_load && !tx_push && tx_cnt == 5'h01 && !multi_q)
        hold_cnt_q <= ct; // RULE_14
      else if (tick && hold_cnt_q != 8'h00)
        hold_cnt_q <= hold_cnt_q - 8'h01;
      if ((empty_ok && !empty_ok_q) ||
          (empty_ok && irq_en_q[`IE_HOLD_EMPTY] && !ie_hold_q))
        hold_pend_q <= 1'b1; // RULE_13
      else if (wr_data || (rd && idx == `IDX_IRQ_ID && id_hold_q))
        hold_pend_q <= 1'b0; // RULE_20
    end
  end

  // Receive side: overrun, error count and character timeout
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_q <= 1'b0;
      err_cnt_q <= 5'h00;
      to_cnt_q <= 10'h000;
      timeout_q <= 1'b0;
    end else begin
      if (rx_done && rx_full) overrun_q <= 1'b1; // RULE_16
      else if (rd && idx == `IDX_LINE_STAT && oe_seen_q) overrun_q <= 1'b0;
      if (rx_clr) err_cnt_q <= 5'h00;
      else err_cnt_q <= err_cnt_q +
                        {4'h0, rx_push && (rx_pe | rx_fe | rx_bi)} -
                        {4'h0, rx_pop && (rx_head[10:8] != 3'b000)};
      if (rx_push || rx_pop || !rx_any || rx_clr) begin
        to_cnt_q <= 10'h000; // RULE_18
        timeout_q <= 1'b0;
      end else if (tick && !timeout_q) begin
        to_cnt_q <= to_cnt_q + 10'h001;
        if (to_cnt_q == to_limit) timeout_q <= 1'b1; // RULE_17
      end
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .PTR_W(PTR_W)) u_tx_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .clear (tx_clr),
    .push  (tx_push),
    .din   (wb),
    .pop   (tx_load),
    .head  (tx_head),
    .count (tx_cnt)
  );

  byte_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH), .PTR_W(PTR_W)) u_rx_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .clear (rx_clr),
    .push  (rx_push),
    .din   ({rx_bi, rx_fe, rx_pe, rx_data}),
    .pop   (rx_pop),
    .head  (rx_head),
    .count (rx_cnt)
  );

  rx_deserializer u_rx (
    .clk       (pclk),
    .rst_n     (presetn),
    .tick      (tick),
    .rxd       (rx_pin),
    .word_len  (line_format_q[1:0]),
    .par_en    (line_format_q[`LF_PAR_EN]),
    .even_par  (line_format_q[`LF_EVEN]),
    .stick_par (line_format_q[`LF_STICK]),
    .done      (rx_done),
    .data      (rx_data),
    .par_err   (rx_pe),
    .frame_err (rx_fe),
    .brk       (rx_bi)
  );
endmodule // uart_fifo_channel
`default_nettype wire

// ---- design/uart_fifo_channel_regs.vh ----
// Register indices, field positions and reset values of the serial channel
`ifndef UART_FIFO_CHANNEL_REGS_VH
`define UART_FIFO_CHANNEL_REGS_VH
`define IDX_DATA        4'h0
`define IDX_IRQ_EN      4'h1
`define IDX_IRQ_ID      4'h2
`define IDX_LINE_FMT    4'h3
`define IDX_MODEM_CTL   4'h4
`define IDX_LINE_STAT   4'h5
`define IDX_MODEM_STAT  4'h6
`define IDX_SCRATCH     4'h7
`define IDX_CONFIG      4'h8
`define IDX_FIFO_SHADOW 4'h9
`define LF_STOP         2
`define LF_PAR_EN       3
`define LF_EVEN         4
`define LF_STICK        5
`define LF_BREAK        6
`define LF_DIV_ACCESS   7
`define MC_OUT_A        2
`define MC_OUT_B        3
`define MC_LOOP         4
`define FC_ENABLE       0
`define FC_RX_CLR       1
`define FC_TX_CLR       2
`define FC_DMA          3
`define IE_RX_DATA      0
`define IE_HOLD_EMPTY   1
`define IE_LINE_STAT    2
`define IE_MODEM_STAT   3
`define CFG_LEGACY      0
`define RESET_BYTE      8'h00
`define RESET_LINE_STAT 8'h60
`define ID_NONE         4'h1
`define ID_LINE_STAT    4'h6
`define ID_RX_DATA      4'h4
`define ID_TIMEOUT      4'hC
`define ID_HOLD_EMPTY   4'h2
`define ID_MODEM_STAT   4'h0
`define TRIG_LVL0       5'h01
`define TRIG_LVL1       5'h04
`define TRIG_LVL2       5'h08
`define TRIG_LVL3       5'h0E
`define SUB_MID         4'h7
`define SUB_LAST        4'hF
`define TIMEOUT_SHIFT   2
`endif

// ---- design/byte_fifo.v ----
// Small synchronous FIFO with occupancy count and synchronous clear
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter PTR_W = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             clear,
  input  wire             push,
  input  wire [WIDTH-1:0] din,
  input  wire             pop,
  output wire [WIDTH-1:0] head,
  output reg  [PTR_W:0]   count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_q;
  reg [PTR_W-1:0] rd_q;
  wire            do_push;
  wire            do_pop;

  assign do_pop  = pop && (count != {(PTR_W+1){1'b0}});
  assign do_push = push && (count != DEPTH[PTR_W:0]);
  assign head    = mem[rd_q];

  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_q] <= din;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= {PTR_W{1'b0}};
      rd_q  <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else if (clear) begin
      wr_q  <= {PTR_W{1'b0}};
      rd_q  <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo
`default_nettype wire

// ---- design/rx_deserializer.v ----
// Receive shifter: start detect, LSB-first data, parity and stop checks
`default_nettype none
`include "uart_fifo_channel_regs.vh"
module rx_deserializer (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       tick,
  input  wire       rxd,
  input  wire [1:0] word_len,
  input  wire       par_en,
  input  wire       even_par,
  input  wire       stick_par,
  output reg        done,
  output reg  [7:0] data,
  output reg        par_err,
  output reg        frame_err,
  output reg        brk
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA  = 3'd2;
  localparam ST_PAR   = 3'd3;
  localparam ST_STOP  = 3'd4;
  reg [2:0] st_q;
  reg [3:0] sub_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg       xor_q;
  reg       pbit_q;
  wire      expect_par;
  wire      bit_end;

  assign bit_end    = tick && (sub_q == `SUB_LAST);
  assign expect_par = stick_par ? ~even_par : (even_par ? xor_q : ~xor_q);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      sub_q <= 4'h0;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      xor_q <= 1'b0;
      pbit_q <= 1'b0;
      done <= 1'b0;
      data <= 8'h00;
      par_err <= 1'b0;
      frame_err <= 1'b0;
      brk <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        sub_q <= sub_q + 1'b1;
      end
      case (st_q)
        ST_IDLE: begin
          sub_q <= 4'h0;
          if (tick && !rxd) begin
            st_q <= ST_START;
          end
        end
        ST_START: begin
          if (tick && sub_q == `SUB_MID) begin
            sub_q <= 4'h0;
            bit_q <= 3'd0;
            sh_q <= 8'h00;
            xor_q <= 1'b0;
            pbit_q <= 1'b0;
            st_q <= rxd ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (bit_end) begin
            sh_q[bit_q] <= rxd; // RULE_02
            xor_q <= xor_q ^ rxd;
            bit_q <= bit_q + 1'b1;
            if (bit_q == {1'b1, word_len}) begin
              st_q <= par_en ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (bit_end) begin
            pbit_q <= rxd;
            st_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (bit_end) begin
            done <= 1'b1;
            data <= sh_q;
            par_err <= par_en && (pbit_q != expect_par);
            frame_err <= ~rxd;
            brk <= ~rxd && (sh_q == 8'h00) && !pbit_q;
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // rx_deserializer
`default_nettype wire

// ---- verification/uart_fifo_channel_chk.sv ----
// Bus and pin checker for the serial channel
`default_nettype none
module uart_fifo_channel_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txd,
  input wire logic        rts_n,
  input wire logic        dtr_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lf_q;
  logic [7:0] mc_q;
  logic       wr_go;
  logic       setup;
  assign wr_go = psel && penable && pready && pwrite;
  assign setup = psel && !penable;
  // Shadow copies of line format and modem control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lf_q <= 8'h00;
      mc_q <= 8'h00;
    end else if (wr_go && paddr == 8'h0C) begin
      lf_q <= pwdata[7:0];
    end else if (wr_go && paddr == 8'h10) begin
      mc_q <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_answer: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  a_err_unmapped: assert property (setup && (paddr[5:2] > 4'h9 ||
    paddr[1:0] != 2'b00) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && paddr[5:2] <= 4'h9 &&
    paddr[7:6] == 2'b00 && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped access refused");
  a_break_low: assert property (lf_q[6] && $past(lf_q[6], 2) &&
    !mc_q[4] && !$past(mc_q[4], 2) |-> !txd)
    else $error("break not holding line low");
  a_loop_quiet: assert property (mc_q[4] && $past(mc_q[4], 2)
    |-> txd && rts_n && dtr_n)
    else $error("pins active in loopback");
  a_modem_outs: assert property (!mc_q[4] && mc_q == $past(mc_q, 2)
    |-> dtr_n == !mc_q[0] && rts_n == !mc_q[1])
    else $error("modem outputs wrong");
endmodule // uart_fifo_channel_chk
bind uart_fifo_channel uart_fifo_channel_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd(txd), .rts_n(rts_n),
  .dtr_n(dtr_n)
);
`default_nettype wire

// ---- verification/serial_peer.sv ----
// Far-end serial sender driving the receive line
`default_nettype none
module serial_peer #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk,
  output var logic  line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // Start, eight data bits, one stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line <= frame[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask
endmodule // serial_peer
`default_nettype wire

// ---- verification/uart_fifo_channel_tb_top.sv ----
// Self-checking bench for the serial channel
`default_nettype none
module uart_fifo_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, e;
  logic [7:0]  paddr, q;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr, rxd, txd, rts_n, dtr_n, irq;
  int          fails = 0;
  int          checks_done = 0;
  uart_fifo_channel u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .cts_n(1'b1), .dsr_n(1'b1), .ri_n(1'b1), .dcd_n(1'b1), .txd(txd),
    .rts_n(rts_n), .dtr_n(dtr_n), .irq(irq)
  );
  serial_peer u_peer (.clk(pclk), .line(rxd));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic t_regs;
    rd(8'h14, 8'h60);
    xfer(1'b1, 8'h0C, 8'h83);
    xfer(1'b1, 8'h00, 8'h01);
    xfer(1'b1, 8'h04, 8'h00);
    rd(8'h00, 8'h01);
    xfer(1'b1, 8'h0C, 8'h03);
    xfer(1'b1, 8'h04, 8'h05);
    rd(8'h04, 8'h05);
    rd(8'h0C, 8'h03);
    xfer(1'b1, 8'h08, 8'h09);
    rd(8'h24, 8'h09);
    rd(8'h08, 8'hC1);
    xfer(1'b1, 8'h08, 8'h00);
    rd(8'h08, 8'h01);
    xfer(1'b1, 8'h20, 8'h01);
    xfer(1'b1, 8'h1C, 8'h5A);
    rd(8'h1C, 8'h00);
    rd(8'h14, 8'h60);
    xfer(1'b1, 8'h20, 8'h00);
    xfer(1'b1, 8'h1C, 8'h5A);
    rd(8'h1C, 8'h5A);
    rd(8'h28, 8'h00);
    chk({7'h00, e}, 8'h01);
  endtask
  task automatic t_tx;
    logic [7:0] b;
    xfer(1'b1, 8'h04, 8'h02);
    xfer(1'b1, 8'h00, 8'hA5);
    for (int n = 0; n < 50 && txd !== 1'b0; n++) @(posedge pclk);
    chk({7'h00, txd}, 8'h00);
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge pclk);
      b[i] = txd;
    end
    chk(b, 8'hA5);
    rd(8'h08, 8'h01);
    repeat (200) @(posedge pclk);
    rd(8'h14, 8'h60);
    rd(8'h08, 8'h02);
    rd(8'h08, 8'h01);
    xfer(1'b1, 8'h0C, 8'h43);
    repeat (4) @(posedge pclk);
    chk({7'h00, txd}, 8'h00);
    xfer(1'b1, 8'h0C, 8'h03);
    xfer(1'b1, 8'h10, 8'h03);
    xfer(1'b1, 8'h10, 8'h13);
    repeat (4) @(posedge pclk);
    chk({5'h00, txd, rts_n, dtr_n}, 8'h07);
    xfer(1'b1, 8'h10, 8'h0C);
    rd(8'h10, 8'h0C);
  endtask
  task automatic t_rx;
    xfer(1'b1, 8'h08, 8'hC1);
    xfer(1'b1, 8'h04, 8'h01);
    for (int i = 0; i < 17; i++) begin
      u_peer.send(8'h30 + i[7:0]);
      repeat (4) @(posedge pclk);
      if (i == 12) rd(8'h08, 8'hC1);
      if (i == 13) rd(8'h08, 8'hC4);
    end
    rd(8'h14, 8'h63);
    for (int i = 0; i < 16; i++) begin
      if (i == 12) xfer(1'b1, 8'h08, 8'h41);
      if (i == 12) rd(8'h08, 8'hC4);
      if (i == 13) rd(8'h08, 8'hC1);
      rd(8'h00, 8'h30 + i[7:0]);
    end
    rd(8'h14, 8'h60);
    u_peer.send(8'h77);
    repeat (300) @(posedge pclk);
    rd(8'h08, 8'hC1);
    repeat (500) @(posedge pclk);
    rd(8'h08, 8'hCC);
    chk({7'h00, irq}, 8'h01);
    rd(8'h00, 8'h77);
    rd(8'h08, 8'hC1);
  endtask
  task automatic summarize;
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hF;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_tx;
    t_rx;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    summarize;
  end
endmodule // uart_fifo_channel_tb_top
`default_nettype wire
